//--- verilog/scd_map.svh
// offsets, codes, limits and reset values of the serial command dispatcher
// assumes nothing; definitions only
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH

// command codes
`define C_LOCK  16'h0808
`define C_COPY  16'h1206
`define C_DEL   16'h1205
`define C_FRD   16'h0610
`define C_FDEL  16'h1610
`define C_GLOB  16'h1618
`define C_INIT  16'h1615
`define C_MODE  16'h1612
`define C_CLR   16'h1617
`define C_LOOP  16'h0619
`define S_FDEL  16'h0001

// payload limits in bytes per exchange
`define L_COPY  10'h1e0
`define L_FRD   10'h050
`define L_LOOP  10'h3c0
`define L_NONE  10'h3ff
`define L_MODE  10'h002

// last header byte index per mode
`define HDR_ASC 3'h7
`define HDR_BIN 3'h3

// ascii hex digit bounds
`define CH_0    8'h30
`define CH_9    8'h39
`define CH_A    8'h41
`define CH_F    8'h46

// error codes
`define E_INIT  8'h00
`define E_CMD   8'h51
`define E_SIZE  8'h52
`define E_STN   8'h53
`define E_CHAR  8'h54
`define E_SHORT 8'h55
`define E_OD    8'h56

// reset values
`define MODE_RST 1'h0
`define SPEC_RST 8'h00

`endif

//--- verilog/scd_pkg.sv
// types shared by the serial command dispatcher
// does not include scd_map.svh; state codes and field widths are set here
package scd_pkg;

    typedef enum logic [1:0] {
        ST_HDR  = 2'b00,
        ST_PAY  = 2'b01,
        ST_SINK = 2'b10
    } state_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } rx_byte_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] cmd;
        logic [15:0] sub;
        logic [9:0]  len;
    } dispatch_s;

    typedef struct packed {
        logic       valid;
        logic       ok;
        logic [7:0] code;
    } rsp_s;

endpackage

//--- verilog/serial_command_dispatcher.sv
// command decoder between a framed serial byte stream and the controller
// assumes framed bytes from a receiver on ref_clk, one byte per valid
//
// How it works
// - header parsed as ascii digits or binary
// - lock command sets or clears file lock
// - copy limited 480 bytes, delete dispatched
// - frame read limited to 80 bytes
// - frame delete needs subcommand 0001
// - global command drives both global signals
// - cpu send request granted if fits
// - binary-only abort returns to command wait
// - mode command sets mode and spec
// - clear command resets led and code
// - loopback echoes, 960 limit, direct only
`timescale 1ns/100ps

`include "scd_map.svh"

module serial_command_dispatcher (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire scd_pkg::rx_byte_s rx,
    input  wire logic              direct_station,
    input  wire logic              cpu_send_req,
    input  wire logic [15:0]       cpu_send_len,
    input  wire logic [15:0]       free_block_len,
    output scd_pkg::dispatch_s     dispatch,
    output scd_pkg::rsp_s          rsp,
    output logic                   err_led,
    output logic [7:0]             err_code,
    output logic                   global_signal_a,
    output logic                   global_signal_b,
    output logic                   file_lock,
    output logic                   mode_binary,
    output logic [7:0]             trans_spec,
    output logic                   tx_valid,
    output logic [7:0]             tx_data,
    output logic                   od_send
);
    import scd_pkg::*;

    // ==========================================================
    // state
    state_e      st_r;
    state_e      st_nxt;
    logic [2:0]  hcnt_r;
    logic [31:0] hdr_r;
    logic [15:0] cmd_r;
    logic [15:0] sub_r;
    logic [9:0]  pcnt_r;
    logic [7:0]  pay0_r;
    logic [7:0]  pay1_r;

    // ==========================================================
    // header decode
    wire in_hdr = rx.valid && st_r == ST_HDR;
    wire in_pay = rx.valid && st_r == ST_PAY;
    wire in_snk = rx.valid && st_r == ST_SINK;

    wire is_dig = rx.data >= `CH_0 && rx.data <= `CH_9;
    wire is_af  = rx.data >= `CH_A && rx.data <= `CH_F;
    wire [3:0] nib = is_dig ? rx.data[3:0] : rx.data[3:0] + 4'h9;
    wire bad_char = in_hdr && !mode_binary && !is_dig && !is_af;

    wire [31:0] asc_nxt = {hdr_r[27:0], nib};
    // binary codes arrive low byte first: cmd lo, cmd hi, sub lo, sub hi
    wire [31:0] bin_nxt = {
        hcnt_r == 3'h1 ? rx.data : hdr_r[31:24],
        hcnt_r == 3'h0 ? rx.data : hdr_r[23:16],
        hcnt_r == 3'h3 ? rx.data : hdr_r[15:8],
        hcnt_r == 3'h2 ? rx.data : hdr_r[7:0]
    };
    wire [31:0] hdr_nxt = mode_binary ? bin_nxt : asc_nxt;
    wire [2:0]  hlast   = mode_binary ? `HDR_BIN : `HDR_ASC;

    wire hdr_done  = in_hdr && !bad_char && hcnt_r == hlast;
    wire short_hdr = in_hdr && rx.last && !bad_char && hcnt_r != hlast;

    wire [15:0] cur_cmd = st_r == ST_HDR ? hdr_nxt[31:16] : cmd_r;
    wire [15:0] cur_sub = st_r == ST_HDR ? hdr_nxt[15:0] : sub_r;

    wire k_lock = cur_cmd == `C_LOCK;
    wire k_copy = cur_cmd == `C_COPY;
    wire k_del  = cur_cmd == `C_DEL;
    wire k_frd  = cur_cmd == `C_FRD;
    wire k_fdel = cur_cmd == `C_FDEL;
    wire k_glob = cur_cmd == `C_GLOB;
    wire k_init = cur_cmd == `C_INIT;
    wire k_mode = cur_cmd == `C_MODE;
    wire k_clr  = cur_cmd == `C_CLR;
    wire k_loop = cur_cmd == `C_LOOP;
    wire sub0   = cur_sub == 16'h0000;

    wire known =
        (k_lock && cur_sub[15:1] == 15'h0000) ||
        ((k_copy || k_del || k_frd || k_mode || k_loop) && sub0) ||
        (k_fdel && cur_sub == `S_FDEL) ||
        (k_glob && cur_sub[15:2] == 14'h0000) ||
        (k_clr && cur_sub[15:4] == 12'h000) ||
        (k_init && sub0 && mode_binary);

    wire bad_cmd = hdr_done && !known;
    wire bad_stn = hdr_done && known && k_loop && !direct_station;

    // ==========================================================
    // payload and limits
    wire [9:0] lim = k_copy ? `L_COPY :
                     k_frd  ? `L_FRD  :
                     k_loop ? `L_LOOP : `L_NONE;
    wire over = in_pay && pcnt_r >= lim;
    wire [9:0] cur_len = in_pay ? pcnt_r + 10'h001 : 10'h000;

    wire fin = rx.last && ((hdr_done && known && !bad_stn) || (in_pay && !over));
    wire short_mode = fin && k_mode && cur_len < `L_MODE;
    wire exec = fin && !short_mode;

    wire req_err = bad_char || short_hdr || bad_cmd || bad_stn ||
                   over || short_mode;
    wire [7:0] req_code = bad_char ? `E_CHAR :
                          (short_hdr || short_mode) ? `E_SHORT :
                          bad_cmd ? `E_CMD :
                          bad_stn ? `E_STN : `E_SIZE;

    // ==========================================================
    // on-demand send from the cpu, independent of the request path
    wire od_fit = cpu_send_len != 16'h0000 &&
                  cpu_send_len <= free_block_len;
    wire od_ok  = cpu_send_req && od_fit;
    wire od_err = cpu_send_req && !od_fit;

    // ==========================================================
    // next values
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_HDR: begin
                if (req_err)
                    st_nxt = rx.last ? ST_HDR : ST_SINK;
                else if (hdr_done && !rx.last)
                    st_nxt = ST_PAY;
            end
            ST_PAY: begin
                if (rx.valid && rx.last)
                    st_nxt = ST_HDR;
                else if (over)
                    st_nxt = ST_SINK;
            end
            ST_SINK: begin
                if (in_snk && rx.last)
                    st_nxt = ST_HDR;
            end
            default: st_nxt = ST_HDR;
        endcase
    end

    wire [2:0] hcnt_nxt = !in_hdr ? hcnt_r :
                          (hdr_done || req_err) ? 3'h0 : hcnt_r + 3'h1;
    wire [9:0] pcnt_nxt = hdr_done ? 10'h000 :
                          in_pay ? pcnt_r + 10'h001 : pcnt_r;

    // an error raised in the same cycle as a clear wins
    wire set_err = req_err || od_err;
    wire err_led_nxt = set_err ? 1'b1 : (exec && k_clr) ? 1'b0 : err_led;
    wire [7:0] err_code_nxt = req_err ? req_code :
                              od_err ? `E_OD :
                              (exec && k_clr) ? `E_INIT : err_code;

    wire [7:0] spec_byte = pcnt_r == 10'h001 ? rx.data : pay1_r;

    // ==========================================================
    // sequencing registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r   <= ST_HDR;
            hcnt_r <= 3'h0;
            hdr_r  <= 32'h0000_0000;
            pcnt_r <= 10'h000;
        end else begin
            st_r   <= st_nxt;
            hcnt_r <= hcnt_nxt;
            hdr_r  <= in_hdr ? hdr_nxt : hdr_r;
            pcnt_r <= pcnt_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_r  <= 16'h0000;
            sub_r  <= 16'h0000;
            pay0_r <= 8'h00;
            pay1_r <= 8'h00;
        end else begin
            if (hdr_done) begin
                cmd_r <= hdr_nxt[31:16];
                sub_r <= hdr_nxt[15:0];
            end
            if (in_pay && pcnt_r == 10'h000)
                pay0_r <= rx.data;
            if (in_pay && pcnt_r == 10'h001)
                pay1_r <= rx.data;
        end
    end

    // ==========================================================
    // controls held by the block
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            file_lock       <= 1'b0;
            global_signal_a <= 1'b0;
            global_signal_b <= 1'b0;
            mode_binary     <= `MODE_RST;
            trans_spec      <= `SPEC_RST;
        end else begin
            if (exec && k_lock)
                file_lock <= cur_sub[0];
            if (exec && k_glob) begin
                global_signal_a <= cur_sub[0];
                global_signal_b <= cur_sub[1];
            end
            // the new mode takes effect on the next request only
            if (exec && k_mode) begin
                mode_binary <= pay0_r[0];
                trans_spec  <= spec_byte;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            err_led  <= 1'b0;
            err_code <= `E_INIT;
        end else begin
            err_led  <= err_led_nxt;
            err_code <= err_code_nxt;
        end
    end

    // ==========================================================
    // answers, dispatch and echo
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rsp      <= '0;
            dispatch <= '0;
        end else begin
            rsp.valid      <= req_err || exec;
            rsp.ok         <= !req_err;
            rsp.code       <= req_err ? req_code : `E_INIT;
            // abort only restarts the receiver, nothing is dispatched
            dispatch.valid <= exec && !k_init;
            dispatch.cmd   <= cur_cmd;
            dispatch.sub   <= cur_sub;
            dispatch.len   <= cur_len;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            od_send  <= 1'b0;
        end else begin
            // echo is cut short at the limit; the host sees an error answer
            tx_valid <= in_pay && k_loop && !over;
            tx_data  <= rx.data;
            od_send  <= od_ok;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_lock;
        exec && k_lock;
    endsequence
    property p_lock;
        s_lock |=> file_lock == $past(cur_sub[0]) && dispatch.valid;
    endproperty
    a_lock: assert property (p_lock) else $error("lock not applied");
    property p_copy;
        dispatch.valid && dispatch.cmd == `C_COPY |-> dispatch.len <= `L_COPY;
    endproperty
    a_copy: assert property (p_copy) else $error("copy over size");
    property p_frd;
        dispatch.valid && dispatch.cmd == `C_FRD |-> dispatch.len <= `L_FRD;
    endproperty
    a_frd: assert property (p_frd) else $error("frame read over size");
    property p_fdel;
        dispatch.valid && dispatch.cmd == `C_FDEL |-> dispatch.sub == `S_FDEL;
    endproperty
    a_fdel: assert property (p_fdel) else $error("bad frame delete");
    property p_glob;
        exec && k_glob |=> global_signal_a == $past(cur_sub[0]) &&
                           global_signal_b == $past(cur_sub[1]);
    endproperty
    a_glob: assert property (p_glob) else $error("global signals wrong");
    property p_od;
        cpu_send_req |=> od_send == ($past(cpu_send_len) != 16'h0000 &&
                         $past(cpu_send_len) <= $past(free_block_len));
    endproperty
    a_od: assert property (p_od) else $error("send grant wrong");
    sequence s_abort;
        exec && k_init;
    endsequence
    property p_init;
        s_abort |=> rsp.valid && rsp.ok && !dispatch.valid && st_r == ST_HDR
                    && mode_binary;
    endproperty
    a_init: assert property (p_init) else $error("abort not clean");
    property p_mode;
        exec && k_mode |=> mode_binary == $past(pay0_r[0]) && trans_spec == $past(spec_byte);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not switched");
    property p_clr;
        exec && k_clr && !od_err |=> !err_led && err_code == `E_INIT;
    endproperty
    a_clr: assert property (p_clr) else $error("error not cleared");
    sequence s_far_loop;
        hdr_done && k_loop && known && !direct_station;
    endsequence
    property p_loop_stn;
        s_far_loop |=> rsp.valid && !rsp.ok && rsp.code == `E_STN ##1 !tx_valid;
    endproperty
    a_loop_stn: assert property (p_loop_stn) else $error("remote loopback");
    property p_loop_len;
        tx_valid |-> tx_data == $past(rx.data) && $past(pcnt_r) < `L_LOOP;
    endproperty
    a_loop_len: assert property (p_loop_len) else $error("echo over size");
    property p_err;
        req_err |=> rsp.valid && !rsp.ok && err_led && err_code == rsp.code;
    endproperty
    a_err: assert property (p_err) else $error("error not reported");

endmodule // serial_command_dispatcher

//--- bench/host_model.sv
// host end of the serial link: frames requests into the received byte stream
// assumes the dispatcher samples rx on the rising edge of ref_clk
`timescale 1ns/100ps

`include "scd_map.svh"

module host_model
    import scd_pkg::*;
(
    input  wire logic         ref_clk,
    output scd_pkg::rx_byte_s rx
);

    initial rx = '0;

    // ========================================
    // framing
    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n < 4'ha) ? `CH_0 + {4'h0, n} : `CH_A + {4'h0, n} - 8'h0a;
    endfunction

    // payload byte i is first + i, so echoes and mode bytes are predictable
    task automatic send(input logic bin, input logic [15:0] cmd, input logic [15:0] sub,
                        input int n, input logic [7:0] first);
        logic [7:0] b;
        logic [15:0] w;
        int hn;
        hn = bin ? 4 : 8;
        for (int i = 0; i < hn + n; i++) begin
            w = (bin ? i[1] : i[2]) ? sub : cmd;
            if (i >= hn)
                b = first + 8'(i - hn);
            else if (bin)
                b = i[0] ? w[15:8] : w[7:0];
            else
                b = hex_char(w[15 - 4 * i[1:0] -: 4]);
            @(negedge ref_clk);
            rx <= '{valid: 1'b1, data: b, last: (i == hn + n - 1)};
        end
        // released line shows the inverse so a stale byte cannot pass for data
        @(negedge ref_clk);
        rx <= '{valid: 1'b0, data: ~rx.data, last: 1'b0};
    endtask

    // one lone byte marked last, for malformed requests
    task automatic send_byte(input logic [7:0] b);
        @(negedge ref_clk);
        rx <= '{valid: 1'b1, data: b, last: 1'b1};
        @(negedge ref_clk);
        rx <= '{valid: 1'b0, data: ~b, last: 1'b0};
    endtask

endmodule // host_model

//--- bench/serial_command_dispatcher_test.sv
// self-checking bench for the serial command dispatcher
// assumes host_model drives rx; inputs change on the falling edge of ref_clk
`timescale 1ns/100ps

`include "scd_map.svh"

module serial_command_dispatcher_test;
    import scd_pkg::*;

    logic               ref_clk;
    logic               nrst;
    rx_byte_s           rx;
    logic               direct_station;
    logic               cpu_send_req;
    logic [15:0]        cpu_send_len;
    logic [15:0]        free_block_len;
    dispatch_s          dispatch;
    rsp_s               rsp;
    logic               err_led;
    logic [7:0]         err_code;
    logic               global_signal_a;
    logic               global_signal_b;
    logic               file_lock;
    logic               mode_binary;
    logic [7:0]         trans_spec;
    logic               tx_valid;
    logic [7:0]         tx_data;
    logic               od_send;
    rsp_s               last_rsp;
    dispatch_s          last_disp;
    int                 rsp_cnt, disp_cnt, od_cnt, cycles, err_count, total_checks;
    logic [7:0]         tx_q[$];

    host_model i_host (.ref_clk(ref_clk), .rx(rx));

    serial_command_dispatcher i_dut (
        .ref_clk(ref_clk), .nrst(nrst), .rx(rx), .direct_station(direct_station),
        .cpu_send_req(cpu_send_req), .cpu_send_len(cpu_send_len),
        .free_block_len(free_block_len), .dispatch(dispatch), .rsp(rsp),
        .err_led(err_led), .err_code(err_code), .global_signal_a(global_signal_a),
        .global_signal_b(global_signal_b), .file_lock(file_lock),
        .mode_binary(mode_binary), .trans_spec(trans_spec), .tx_valid(tx_valid),
        .tx_data(tx_data), .od_send(od_send)
    );

    // ========================================
    // clock, capture and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // one-cycle outputs are caught here so a scenario never misses a pulse
    always @(posedge ref_clk) begin
        cycles++;
        if (rsp.valid === 1'b1) begin
            last_rsp = rsp;
            rsp_cnt++;
        end
        if (dispatch.valid === 1'b1) begin
            last_disp = dispatch;
            disp_cnt++;
        end
        if (tx_valid === 1'b1)
            tx_q.push_back(tx_data);
        if (od_send === 1'b1)
            od_cnt++;
        if (cycles >= 20000) begin
            err_count++;
            finish_test();
        end
    end

    // ========================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic req(input logic bin, input logic [15:0] cmd, input logic [15:0] sub,
                       input int n, input logic [7:0] first, input logic ok,
                       input logic [7:0] code);
        int rc;
        rc = rsp_cnt;
        i_host.send(bin, cmd, sub, n, first);
        for (int k = 0; k < 6 && rsp_cnt == rc; k++)
            @(posedge ref_clk);
        @(negedge ref_clk);
        chk(16'(rsp_cnt - rc), 16'h1, "answer count");
        chk({15'h0, last_rsp.ok}, {15'h0, ok}, "answer ok");
        chk({8'h0, last_rsp.code}, {8'h0, code}, "answer code");
    endtask

    task automatic raw(input logic [7:0] b, input logic [7:0] code);
        int rc;
        rc = rsp_cnt;
        i_host.send_byte(b);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(16'(rsp_cnt - rc), 16'h1, "answer count");
        chk({15'h0, last_rsp.ok}, 16'h0, "answer ok");
        chk({8'h0, last_rsp.code}, {8'h0, code}, "answer code");
    endtask

    task automatic od(input logic [15:0] len, input logic [15:0] free, input logic grant);
        int oc;
        oc = od_cnt;
        cpu_send_req = 1'b1;
        cpu_send_len = len;
        free_block_len = free;
        @(negedge ref_clk);
        cpu_send_req = 1'b0;
        @(negedge ref_clk);
        chk(16'(od_cnt - oc), {15'h0, grant}, "send grants");
        if (!grant)
            chk({8'h0, err_code}, {8'h0, `E_OD}, "send error code");
    endtask

    task automatic finish_test();
        $display("checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ========================================
    // scenarios
    task automatic t_error_clear();
        req(1'b0, 16'h1234, 16'h0000, 0, 8'h00, 1'b0, `E_CMD);
        chk({15'h0, err_led}, 16'h1, "led after error");
        req(1'b0, `C_CLR, 16'h0000, 0, 8'h00, 1'b1, `E_INIT);
        chk({15'h0, err_led}, 16'h0, "led after clear");
        chk({8'h0, err_code}, {8'h0, `E_INIT}, "code after clear");
        chk(last_disp.cmd, `C_CLR, "ascii command decode");
    endtask

    task automatic t_lock_global();
        req(1'b0, `C_LOCK, 16'h0001, 0, 8'h00, 1'b1, 8'h00);
        chk({15'h0, file_lock}, 16'h1, "lock set");
        req(1'b0, `C_LOCK, 16'h0000, 0, 8'h00, 1'b1, 8'h00);
        chk({15'h0, file_lock}, 16'h0, "lock clear");
        for (int s = 3; s >= 0; s--) begin
            req(1'b0, `C_GLOB, 16'(s), 0, 8'h00, 1'b1, 8'h00);
            chk({14'h0, global_signal_b, global_signal_a}, 16'(s), "global pair");
        end
        req(1'b0, `C_GLOB, 16'h0004, 0, 8'h00, 1'b0, `E_CMD);
    endtask

    task automatic t_file_frame();
        req(1'b0, `C_COPY, 16'h0000, 480, 8'h00, 1'b1, 8'h00);
        chk({6'h0, last_disp.len}, {6'h0, `L_COPY}, "copy length");
        req(1'b0, `C_COPY, 16'h0000, 481, 8'h00, 1'b0, `E_SIZE);
        req(1'b0, `C_DEL, 16'h0000, 0, 8'h00, 1'b1, 8'h00);
        chk(last_disp.cmd, `C_DEL, "delete dispatched");
        req(1'b0, `C_FRD, 16'h0000, 80, 8'h00, 1'b1, 8'h00);
        req(1'b0, `C_FRD, 16'h0000, 81, 8'h00, 1'b0, `E_SIZE);
        req(1'b0, `C_FDEL, `S_FDEL, 0, 8'h00, 1'b1, 8'h00);
        chk(last_disp.sub, `S_FDEL, "frame delete sub");
        req(1'b0, `C_FDEL, 16'h0000, 0, 8'h00, 1'b0, `E_CMD);
    endtask

    task automatic t_mode_init();
        int dc;
        raw(8'h67, `E_CHAR);
        raw(`CH_0, `E_SHORT);
        req(1'b0, `C_MODE, 16'h0000, 1, 8'h01, 1'b0, `E_SHORT);
        chk({15'h0, mode_binary}, 16'h0, "mode kept");
        req(1'b0, `C_INIT, 16'h0000, 0, 8'h00, 1'b0, `E_CMD);
        req(1'b0, `C_MODE, 16'h0000, 2, 8'h01, 1'b1, 8'h00);
        chk({15'h0, mode_binary}, 16'h1, "binary mode");
        chk({8'h0, trans_spec}, 16'h0002, "spec byte");
        dc = disp_cnt;
        req(1'b1, `C_INIT, 16'h0000, 0, 8'h00, 1'b1, 8'h00);
        chk(16'(disp_cnt - dc), 16'h0, "abort not dispatched");
    endtask

    task automatic t_loop();
        direct_station = 1'b1;
        tx_q.delete();
        req(1'b1, `C_LOOP, 16'h0000, 3, 8'ha0, 1'b1, 8'h00);
        chk(16'(tx_q.size()), 16'h3, "echo count");
        foreach (tx_q[i])
            chk({8'h0, tx_q[i]}, 16'h00a0 + 16'(i), "echo byte");
        tx_q.delete();
        req(1'b1, `C_LOOP, 16'h0000, 960, 8'h00, 1'b1, 8'h00);
        chk(16'(tx_q.size()), 16'd960, "long echo count");
        req(1'b1, `C_LOOP, 16'h0000, 961, 8'h00, 1'b0, `E_SIZE);
        direct_station = 1'b0;
        req(1'b1, `C_LOOP, 16'h0000, 1, 8'h00, 1'b0, `E_STN);
        req(1'b1, `C_CLR, 16'h0000, 0, 8'h00, 1'b1, `E_INIT);
    endtask

    // ========================================
    // main sequence
    initial begin
        nrst = 1'b0;
        direct_station = 1'b1;
        cpu_send_req = 1'b0;
        cpu_send_len = 16'h0000;
        free_block_len = 16'h0000;
        repeat (20) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        chk({8'h0, err_code}, {8'h0, `E_INIT}, "reset code");
        t_error_clear();
        t_lock_global();
        t_file_frame();
        od(16'h000a, 16'h0014, 1'b1);
        od(16'h0014, 16'h0014, 1'b1);
        od(16'h0015, 16'h0014, 1'b0);
        od(16'h0000, 16'h0014, 1'b0);
        t_mode_init();
        t_loop();
        finish_test();
    end

endmodule // serial_command_dispatcher_test
